// ---- rtl/ees_mem.sv ----
// 256 x 8 storage array with registered read data
`timescale 1ns/100ps
`default_nettype none
module ees_mem (
  input  wire logic                      clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      we_i,
  input  wire logic [ees_pkg::ADDR_W-1:0] waddr_i,
  input  wire logic [ees_pkg::DATA_W-1:0] wdata_i,
  input  wire logic [ees_pkg::ADDR_W-1:0] raddr_i,
  output logic      [ees_pkg::DATA_W-1:0] rdata_o
);

  logic [ees_pkg::DATA_W-1:0] mem_reg [ees_pkg::MEM_DEPTH];
  logic [ees_pkg::DATA_W-1:0] rdata_reg;

  // array has no reset: contents are data, not control state
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= mem_reg[raddr_i];
    end
  end

  assign rdata_o = rdata_reg;

endmodule
`default_nettype wire

// ---- rtl/ees_pkg.sv ----
// constants and types shared by the serial eeprom read and poll logic
package ees_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned NS_PER_US     = 1000;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CS_W          = 3;
  localparam int unsigned CNT_W         = 4;
  localparam int unsigned PAGE_W        = 4;
  localparam int unsigned BUSY_W        = 20;
  localparam int unsigned MEM_DEPTH     = 256;

  // control byte layout and device-type code
  localparam logic [3:0]   DEV_CODE     = 4'hA;
  localparam int unsigned  CODE_MSB     = 7;
  localparam int unsigned  CODE_LSB     = 4;
  localparam int unsigned  CS_MSB       = 3;
  localparam int unsigned  CS_LSB       = 1;
  localparam int unsigned  RW_BIT       = 0;

  localparam logic [CNT_W-1:0]  BYTE_BITS = 4'h8;
  localparam logic [CNT_W-1:0]  LAST_BIT  = 4'h7;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 8'h01;
  localparam logic [PAGE_W-1:0] PAGE_ONE  = 4'h1;
  localparam logic [BUSY_W-1:0] BUSY_ZERO = 20'h00000;
  localparam logic [BUSY_W-1:0] BUSY_ONE  = 20'h00001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h2,
    ST_TX   = 3'h3,
    ST_MACK = 3'h4
  } ees_state_t;

  typedef enum logic [1:0] {
    BK_CTRL  = 2'h0,
    BK_WADDR = 2'h1,
    BK_DATA  = 2'h2
  } ees_kind_t;

endpackage

// ---- rtl/ees_slave.sv ----
// two-wire serial eeprom slave: reads, pointer, busy polling
`timescale 1ns/100ps
`default_nettype none
module ees_slave #(
  parameter int unsigned WR_TIME_US = 5000
) (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe_o,
  input  wire logic [ees_pkg::CS_W-1:0] chip_select_pins_i,
  output logic                         busy_o
);

  localparam logic [ees_pkg::BUSY_W-1:0] WR_CYCLES =
    ees_pkg::BUSY_W'((WR_TIME_US * ees_pkg::NS_PER_US) / ees_pkg::CLK_PERIOD_NS);

  // synchronisers; the first stage feeds only the second
  logic                      scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic                      sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic [ees_pkg::CS_W-1:0]  cs_meta_reg, cs_sync_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_meta_reg <= 1'h1;
      scl_sync_reg <= 1'h1;
      scl_prev_reg <= 1'h1;
      sda_meta_reg <= 1'h1;
      sda_sync_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
      cs_meta_reg  <= 3'h0;
      cs_sync_reg  <= 3'h0;
    end else begin
      scl_meta_reg <= scl_i;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      cs_meta_reg  <= chip_select_pins_i;
      cs_sync_reg  <= cs_meta_reg;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall  = ~scl_sync_reg & scl_prev_reg;
  assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign stop_det  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

  ees_pkg::ees_state_t          state_reg, state_next;
  ees_pkg::ees_kind_t           kind_reg, kind_next;
  logic [ees_pkg::CNT_W-1:0]    cnt_reg, cnt_next;
  logic [ees_pkg::DATA_W-1:0]   sr_reg, sr_next;
  logic [ees_pkg::DATA_W-1:0]   tx_reg, tx_next;
  logic [ees_pkg::ADDR_W-1:0]   ptr_reg, ptr_next;
  logic                         oe_reg, oe_next;
  logic                         rd_reg, rd_next;
  logic                         mack_reg, mack_next;
  logic                         wpend_reg, wpend_next;
  logic                         busy_reg, busy_next;
  logic [ees_pkg::BUSY_W-1:0]   bcnt_reg, bcnt_next;
  logic                         mem_we;
  logic [ees_pkg::DATA_W-1:0]   rd_data;
  logic                         rx_done, ctrl_match;

  assign rx_done    = scl_fall && (state_reg == ees_pkg::ST_RX) && (cnt_reg == ees_pkg::BYTE_BITS);
  assign ctrl_match = (sr_reg[ees_pkg::CODE_MSB:ees_pkg::CODE_LSB] == ees_pkg::DEV_CODE) &&
                      (sr_reg[ees_pkg::CS_MSB:ees_pkg::CS_LSB] == cs_sync_reg);

  // read port follows the pointer, so the next byte is ready long before it is needed
  ees_mem u_mem (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .we_i    (mem_we),
    .waddr_i (ptr_reg),
    .wdata_i (sr_reg),
    .raddr_i (ptr_reg),
    .rdata_o (rd_data)
  );

  always_comb begin
    state_next = state_reg;
    kind_next  = kind_reg;
    cnt_next   = cnt_reg;
    sr_next    = sr_reg;
    tx_next    = tx_reg;
    ptr_next   = ptr_reg;
    oe_next    = oe_reg;
    rd_next    = rd_reg;
    mack_next  = mack_reg;
    wpend_next = wpend_reg;
    busy_next  = busy_reg;
    bcnt_next  = bcnt_reg;
    mem_we     = 1'h0;
    if (busy_reg) begin
      if (bcnt_reg == ees_pkg::BUSY_ZERO) begin
        busy_next = 1'h0;
      end else begin
        bcnt_next = bcnt_reg - ees_pkg::BUSY_ONE;
      end
    end
    if (start_det) begin
      state_next = ees_pkg::ST_RX;
      kind_next  = ees_pkg::BK_CTRL;
      cnt_next   = ees_pkg::CNT_ZERO;
      oe_next    = 1'h0;
      wpend_next = 1'h0;
    end else if (stop_det) begin
      state_next = ees_pkg::ST_IDLE;
      oe_next    = 1'h0;
      if (wpend_reg) begin
        busy_next  = 1'h1;
        bcnt_next  = WR_CYCLES - ees_pkg::BUSY_ONE;
        wpend_next = 1'h0;
      end
    end else begin
      unique case (state_reg)
        ees_pkg::ST_IDLE: begin
        end
        ees_pkg::ST_RX: begin
          if (scl_rise && (cnt_reg != ees_pkg::BYTE_BITS)) begin
            sr_next  = {sr_reg[ees_pkg::DATA_W-2:0], sda_sync_reg};
            cnt_next = cnt_reg + ees_pkg::CNT_ONE;
          end
          if (rx_done) begin
            unique case (kind_reg)
              ees_pkg::BK_CTRL: begin
                if (ctrl_match && !busy_reg) begin
                  oe_next    = 1'h1;
                  state_next = ees_pkg::ST_ACK;
                  rd_next    = sr_reg[ees_pkg::RW_BIT];
                end else begin
                  state_next = ees_pkg::ST_IDLE;
                end
              end
              ees_pkg::BK_WADDR: begin
                ptr_next   = sr_reg;
                oe_next    = 1'h1;
                state_next = ees_pkg::ST_ACK;
              end
              default: begin
                // written at once; page roll keeps the upper nibble
                mem_we     = 1'h1;
                ptr_next   = {ptr_reg[ees_pkg::ADDR_W-1:ees_pkg::PAGE_W],
                              ptr_reg[ees_pkg::PAGE_W-1:0] + ees_pkg::PAGE_ONE};
                wpend_next = 1'h1;
                oe_next    = 1'h1;
                state_next = ees_pkg::ST_ACK;
              end
            endcase
          end
        end
        ees_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_next = ees_pkg::CNT_ZERO;
            if ((kind_reg == ees_pkg::BK_CTRL) && rd_reg) begin
              tx_next    = rd_data;
              oe_next    = ~rd_data[ees_pkg::DATA_W-1];
              state_next = ees_pkg::ST_TX;
            end else begin
              oe_next    = 1'h0;
              state_next = ees_pkg::ST_RX;
              kind_next  = (kind_reg == ees_pkg::BK_CTRL) ? ees_pkg::BK_WADDR
                                                          : ees_pkg::BK_DATA;
            end
          end
        end
        ees_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_reg == ees_pkg::LAST_BIT) begin
              oe_next    = 1'h0;
              state_next = ees_pkg::ST_MACK;
              ptr_next   = ptr_reg + ees_pkg::ADDR_ONE;
            end else begin
              tx_next  = {tx_reg[ees_pkg::DATA_W-2:0], 1'h0};
              oe_next  = ~tx_reg[ees_pkg::DATA_W-2];
              cnt_next = cnt_reg + ees_pkg::CNT_ONE;
            end
          end
        end
        ees_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_next = ~sda_sync_reg;
          end
          if (scl_fall) begin
            if (mack_reg) begin
              tx_next    = rd_data;
              oe_next    = ~rd_data[ees_pkg::DATA_W-1];
              cnt_next   = ees_pkg::CNT_ZERO;
              state_next = ees_pkg::ST_TX;
            end else begin
              oe_next    = 1'h0;
              state_next = ees_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          oe_next    = 1'h0;
          state_next = ees_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ees_pkg::ST_IDLE;
      kind_reg  <= ees_pkg::BK_CTRL;
      cnt_reg   <= ees_pkg::CNT_ZERO;
      sr_reg    <= 8'h00;
      tx_reg    <= 8'h00;
      ptr_reg   <= 8'h00;
      oe_reg    <= 1'h0;
      rd_reg    <= 1'h0;
      mack_reg  <= 1'h0;
      wpend_reg <= 1'h0;
      busy_reg  <= 1'h0;
      bcnt_reg  <= ees_pkg::BUSY_ZERO;
    end else begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
      cnt_reg   <= cnt_next;
      sr_reg    <= sr_next;
      tx_reg    <= tx_next;
      ptr_reg   <= ptr_next;
      oe_reg    <= oe_next;
      rd_reg    <= rd_next;
      mack_reg  <= mack_next;
      wpend_reg <= wpend_next;
      busy_reg  <= busy_next;
      bcnt_reg  <= bcnt_next;
    end
  end

  // open drain: only ever pulls low
  assign sda_o    = 1'h0;
  assign sda_oe_o = oe_reg;
  assign busy_o   = busy_reg;

  property p_busy_nack;
    @(posedge clk_i) disable iff (!nrst_i)
    (rx_done && kind_reg == ees_pkg::BK_CTRL && busy_reg && !start_det && !stop_det)
      |=> (!oe_reg && state_reg == ees_pkg::ST_IDLE);
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack given while busy");

  property p_stop_launch;
    @(posedge clk_i) disable iff (!nrst_i)
    (stop_det && !start_det && wpend_reg) |=> (busy_reg && bcnt_reg == WR_CYCLES - 20'h00001);
  endproperty
  a_stop_launch: assert property (p_stop_launch) else $error("write cycle not started");

  property p_restart_no_cycle;
    @(posedge clk_i) disable iff (!nrst_i)
    (start_det && !busy_reg) |=> (!busy_reg && !wpend_reg);
  endproperty
  a_restart_no_cycle: assert property (p_restart_no_cycle) else $error("restart started cycle");

  property p_code_reject;
    @(posedge clk_i) disable iff (!nrst_i)
    (rx_done && kind_reg == ees_pkg::BK_CTRL && !ctrl_match && !start_det && !stop_det)
      |=> !oe_reg;
  endproperty
  a_code_reject: assert property (p_code_reject) else $error("foreign control byte acked");

  property p_poll_ack;
    @(posedge clk_i) disable iff (!nrst_i)
    (rx_done && kind_reg == ees_pkg::BK_CTRL && ctrl_match && !busy_reg && !start_det && !stop_det)
      |=> (oe_reg && state_reg == ees_pkg::ST_ACK);
  endproperty
  a_poll_ack: assert property (p_poll_ack) else $error("idle device did not ack");

  property p_ptr_step;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ees_pkg::ST_TX && scl_fall && cnt_reg == ees_pkg::LAST_BIT && !start_det && !stop_det)
      |=> (ptr_reg == ees_pkg::ADDR_W'($past(ptr_reg) + 8'h01));
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");

  property p_ptr_wrap;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ees_pkg::ST_TX && scl_fall && cnt_reg == ees_pkg::LAST_BIT &&
     ptr_reg == 8'hFF && !start_det && !stop_det) |=> (ptr_reg == 8'h00);
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

  property p_addr_load;
    @(posedge clk_i) disable iff (!nrst_i)
    (rx_done && kind_reg == ees_pkg::BK_WADDR && !start_det && !stop_det)
      |=> (ptr_reg == $past(sr_reg));
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("word address not loaded");

  property p_release;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ees_pkg::ST_MACK && scl_fall && !mack_reg && !start_det && !stop_det)
      |=> (!oe_reg && state_reg == ees_pkg::ST_IDLE);
  endproperty
  a_release: assert property (p_release) else $error("line not released");

  property p_tx_drive;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ees_pkg::ST_TX) |-> (oe_reg == ~tx_reg[ees_pkg::DATA_W-1]);
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("driven bit differs");

  c_read_byte: cover property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == ees_pkg::ST_TX ##1 state_reg == ees_pkg::ST_MACK);
  c_seq_read: cover property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == ees_pkg::ST_MACK && scl_fall && mack_reg);
  c_poll_nack: cover property (@(posedge clk_i) disable iff (!nrst_i)
    rx_done && kind_reg == ees_pkg::BK_CTRL && busy_reg);
  c_cycle: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(busy_reg));

endmodule
`default_nettype wire

// ---- verification/eeprom_serial_read_and_poll_tb_top.sv ----
// self-checking bench for the serial eeprom read and poll slave
`timescale 1ns/100ps
`default_nettype none
module eeprom_serial_read_and_poll_tb_top;
  // long enough that the first poll after the refused read still meets a busy device
  localparam int unsigned WR_US = 2;
  localparam logic [2:0]  CS    = 3'h5;
  localparam logic [7:0]  CW    = {ees_pkg::DEV_CODE, CS, 1'b0};
  localparam logic [7:0]  CR    = {ees_pkg::DEV_CODE, CS, 1'b1};

  logic       clk;
  logic       nrst;
  logic [2:0] cs_pins;
  wire logic  scl;
  wire logic  m_oe;
  wire logic  s_oe;
  wire logic  s_do;
  wire logic  busy;
  wire logic  sda;
  int         failures;
  int         compares;

  // pull-up wire: either party may only pull low
  assign sda = ~(m_oe | (s_oe & ~s_do));

  ees_slave #(.WR_TIME_US(WR_US)) i_ees_slave (
    .clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .sda_o(s_do),
    .sda_oe_o(s_oe), .chip_select_pins_i(cs_pins), .busy_o(busy)
  );

  ees_master_model i_ees_master_model (
    .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] pattern(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // write n bytes, then poll for the end of the write cycle
  task automatic sc_write_poll(input logic [7:0] addr, input int n);
    logic ack;
    int   polls;
    i_ees_master_model.start_cond();
    i_ees_master_model.send_byte(CW, ack);
    check("ctrl ack", {7'h0, ack}, 8'h01);
    i_ees_master_model.send_byte(addr, ack);
    for (int k = 0; k < n; k++) begin
      i_ees_master_model.send_byte(pattern(addr + 8'(k)), ack);
    end
    i_ees_master_model.stop_cond();
    repeat (2) @(posedge clk);
    check("busy after stop", {7'h0, busy}, 8'h01);
    i_ees_master_model.start_cond();
    i_ees_master_model.send_byte(CR, ack);
    check("ack while busy", {7'h0, ack}, 8'h00);
    i_ees_master_model.poll_ready(CW, polls);
    check("polls refused", {7'h0, polls > 1}, 8'h01);
    check("acked when idle", {7'h0, polls < 40}, 8'h01);
    check("busy at ack", {7'h0, busy}, 8'h00);
    i_ees_master_model.stop_cond();
  endtask

  // word address inside a write, left by a repeated start
  task automatic set_ptr(input logic [7:0] addr);
    logic ack;
    i_ees_master_model.start_cond();
    i_ees_master_model.send_byte(CW, ack);
    i_ees_master_model.send_byte(addr, ack);
    check("address ack", {7'h0, ack}, 8'h01);
  endtask

  task automatic read_seq(input logic [7:0] first, input int count);
    logic       ack;
    logic       line;
    logic [7:0] d;
    i_ees_master_model.start_cond();
    i_ees_master_model.send_byte(CR, ack);
    check("read ctrl ack", {7'h0, ack}, 8'h01);
    for (int k = 0; k < count; k++) begin
      i_ees_master_model.recv_byte(k < count - 1, d, line);
      check("read data", d, pattern(first + 8'(k)));
    end
    check("line after no-ack", {7'h0, line}, 8'h01);
    i_ees_master_model.stop_cond();
  endtask

  task automatic sc_random_then_current();
    set_ptr(8'hFE);
    read_seq(8'hFE, 1);
    check("busy after aborted write", {7'h0, busy}, 8'h00);
    read_seq(8'hFF, 1);
  endtask

  task automatic sc_seq_wrap();
    set_ptr(8'hFD);
    read_seq(8'hFD, 5);
    read_seq(8'h02, 1);
  endtask

  task automatic sc_refuse();
    logic       ack;
    logic [7:0] bad[3];
    bad = '{{4'hB, CS, 1'b1}, {4'h2, CS, 1'b0}, {ees_pkg::DEV_CODE, CS ^ 3'h2, 1'b1}};
    for (int k = 0; k < 3; k++) begin
      i_ees_master_model.start_cond();
      i_ees_master_model.send_byte(bad[k], ack);
      check("foreign ctrl ack", {7'h0, ack}, 8'h00);
      i_ees_master_model.stop_cond();
    end
    read_seq(8'h03, 1);
  endtask

  initial begin
    failures = 0;
    compares = 0;
    nrst     = 1'b0;
    cs_pins  = CS;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    sc_write_poll(8'hFC, 4);
    sc_write_poll(8'h00, 4);
    sc_random_then_current();
    sc_seq_wrap();
    sc_refuse();
    report_and_stop();
  end

  // whole run needs well under 20000 cycles
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- verification/ees_master_model.sv ----
// two-wire bus master model: drives the link clock and pulls the data line low
`timescale 1ns/100ps
`default_nettype none
module ees_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // the link clock stands high between frames, data released
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  // one bit slot of ten cycles: data moves in the low phase, sampled mid-high
  task automatic bit_slot(input logic b, output logic r);
    sda_oe_o <= ~b;
    repeat (3) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    r = sda_i;
    repeat (2) @(posedge clk_i);
    scl_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // also used as repeated start, entered with the clock low
  task automatic start_cond();
    sda_oe_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_oe_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic stop_cond();
    sda_oe_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_oe_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], r);
    end
    bit_slot(1'b1, r);
    ack = ~r;
  endtask

  // master ack asks for more, no-ack ends
  task automatic recv_byte(input logic mack, output logic [7:0] d, output logic line);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, d[i]);
    end
    bit_slot(~mack, line);
  endtask

  // resend start and control until acked
  task automatic poll_ready(input logic [7:0] ctrl, output int n);
    logic ack;
    n = 0;
    do begin
      start_cond();
      send_byte(ctrl, ack);
      n++;
    end while (!ack && n < 40);
  endtask
endmodule
`default_nettype wire
